// file: logic/pfm_pkg.sv
// Constants for the upper-port pin function multiplexer
package pfm_pkg;
   localparam int AW = 8;
   localparam int DW = 32;
   // Port widths
   localparam int P6_W  = 8;
   localparam int P7_W  = 3;
   localparam int P8_W  = 8;
   localparam int P9_W  = 7;
   localparam int P10_W = 4;
   localparam int P12_W = 8;
   localparam int P13_W = 2;
   // Register byte offsets
   localparam logic [AW-1:0] OFS_P6_LATCH   = 8'h00;
   localparam logic [AW-1:0] OFS_P7_LATCH   = 8'h04;
   localparam logic [AW-1:0] OFS_P8_LATCH   = 8'h08;
   localparam logic [AW-1:0] OFS_P9_LATCH   = 8'h0C;
   localparam logic [AW-1:0] OFS_P10_LATCH  = 8'h10;
   localparam logic [AW-1:0] OFS_P12_LATCH  = 8'h14;
   localparam logic [AW-1:0] OFS_P13_LATCH  = 8'h18;
   localparam logic [AW-1:0] OFS_P6_DIR     = 8'h20;
   localparam logic [AW-1:0] OFS_P7_DIR     = 8'h24;
   localparam logic [AW-1:0] OFS_P8_DIR     = 8'h28;
   localparam logic [AW-1:0] OFS_P9_DIR     = 8'h2C;
   localparam logic [AW-1:0] OFS_P10_DIR    = 8'h30;
   localparam logic [AW-1:0] OFS_P12_DIR    = 8'h34;
   localparam logic [AW-1:0] OFS_P13_DIR    = 8'h38;
   localparam logic [AW-1:0] OFS_PU_LOW     = 8'h40;
   localparam logic [AW-1:0] OFS_PU_HIGH    = 8'h44;
   localparam logic [AW-1:0] OFS_MEM_CTRL   = 8'h48;
   localparam logic [AW-1:0] OFS_SER_CTRL   = 8'h4C;
   localparam logic [AW-1:0] OFS_P7_CTL     = 8'h50;
   localparam logic [AW-1:0] OFS_P10_CTL    = 8'h54;
   localparam logic [AW-1:0] OFS_P12_CTL    = 8'h58;
   localparam logic [AW-1:0] OFS_P13_CTL    = 8'h5C;
   localparam logic [AW-1:0] OFS_RT_BUF     = 8'h60;
   // Field positions
   localparam int MEM_EXP_BIT   = 0;
   localparam int MEM_WAIT_BIT  = 1;
   localparam int SER_ASYNC_BIT = 0;
   localparam int PUL_P6_BIT    = 6;
   localparam int PUL_P7_BIT    = 7;
   localparam int PUH_P8_BIT    = 0;
   localparam int PUH_P9_BIT    = 1;
   localparam int PUH_P10_BIT   = 2;
   localparam int PUH_P12_BIT   = 4;
   localparam int PUH_P13_BIT   = 5;
   // Reset values: every pin an input, latches low, options off
   localparam logic [7:0] RST_DIR   = 8'hFF;
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [7:0] RST_OPT   = 8'h00;
   // Pin properties
   localparam logic [P6_W-1:0]  P6_OD_MASK  = 8'h0F;
   localparam logic [P6_W-1:0]  P6_PU_MASK  = 8'hF0;
   localparam logic [P9_W-1:0]  P9_OD_MASK  = 7'h0F;
   localparam logic [P9_W-1:0]  P9_PU_MASK  = 7'h70;
   localparam logic [P10_W-1:0] P10_ALT_MASK = 4'h3;
endpackage : pfm_pkg

// file: logic/pfm_pin_cell.sv
// Per-bit pin cell: port latch or alternate function, direction and pull-up
`timescale 1ns/10ps
module pfm_pin_cell #(
   parameter int           W       = 8,
   parameter logic [W-1:0] OD_MASK = '0,
   parameter logic [W-1:0] PU_MASK = '1
) (
   input  wire logic [W-1:0] latch,
   input  wire logic [W-1:0] dir,
   input  wire logic [W-1:0] ctl,
   input  wire logic [W-1:0] alt_o,
   input  wire logic [W-1:0] alt_oe,
   input  wire logic [W-1:0] pin_i,
   input  wire logic         pu_opt,
   output logic      [W-1:0] pin_o,
   output logic      [W-1:0] pin_oe,
   output logic      [W-1:0] pull_en,
   output logic      [W-1:0] rd_val
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // Alternate function owns value and enable in control mode
         assign pin_o[i]  = ctl[i] ? alt_o[i] : (OD_MASK[i] ? 1'b0 : latch[i]);
         assign pin_oe[i] = ctl[i] ? alt_oe[i]
                          : (OD_MASK[i] ? (~dir[i] & ~latch[i]) : ~dir[i]);
         // Pull-up only on inputs in port mode; control mode always releases it
         assign pull_en[i] = pu_opt & PU_MASK[i] & dir[i] & ~ctl[i];
         assign rd_val[i]  = dir[i] ? pin_i[i] : latch[i];
      end
   endgenerate
endmodule : pfm_pin_cell

// file: logic/pfm_rt_buffer.sv
// Real-time output buffer: loads the pin data on each trigger pulse
`timescale 1ns/10ps
module pfm_rt_buffer
   import pfm_pkg::*;
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             buf_we,
   input  wire logic [P12_W-1:0] buf_wdata,
   input  wire logic             trigger,
   output logic      [P12_W-1:0] buf_q,
   output logic      [P12_W-1:0] out_q
);
   logic [P12_W-1:0] buf_r;
   logic [P12_W-1:0] out_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_r <= RST_LATCH;
      end else if (buf_we) begin
         buf_r <= buf_wdata;
      end
   end

   // Trigger in the same cycle as a write moves the new value straight out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_r <= RST_LATCH;
      end else if (trigger) begin
         out_r <= buf_we ? buf_wdata : buf_r;
      end
   end

   assign buf_q = buf_r;
   assign out_q = out_r;
endmodule : pfm_rt_buffer

// file: logic/pfm_port_mux.sv
// Upper-port pin function multiplexer with APB register file
`timescale 1ns/10ps
module pfm_port_mux
   import pfm_pkg::*;
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   // APB slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [AW-1:0]    paddr,
   input  wire logic [DW-1:0]    pwdata,
   output logic      [DW-1:0]    prdata,
   output logic                  pready,
   output logic                  pslverr,
   // External memory bus controller
   input  wire logic             mem_rd_strobe_n,
   input  wire logic             mem_wr_strobe_n,
   input  wire logic             address_latch_strobe,
   input  wire logic [P8_W-1:0]  mem_addr_lo,
   output logic                  mem_wait_n,
   // Serial channel 2
   input  wire logic             sync_serial_out_ch2,
   input  wire logic             sync_serial_clock_ch2,
   input  wire logic             sync_serial_clock_ch2_oe,
   input  wire logic             async_txd,
   output logic                  sync_serial_in_ch2,
   output logic                  sync_serial_clock_in,
   output logic                  async_rxd,
   output logic                  async_baud_clock_in,
   // Timers 5 and 6
   input  wire logic             timer5_output,
   input  wire logic             timer6_output,
   input  wire logic             timer5_out_en,
   input  wire logic             timer6_out_en,
   output logic                  timer5_ext_clock,
   output logic                  timer6_ext_clock,
   // Real-time output trigger and DAC switch
   input  wire logic             realtime_trigger,
   output logic      [P13_W-1:0] dac_out_enable,
   // Pins
   input  wire logic [P6_W-1:0]  port6_i,
   output logic      [P6_W-1:0]  port6_o,
   output logic      [P6_W-1:0]  port6_oe,
   output logic      [P6_W-1:0]  port6_pu,
   input  wire logic [P7_W-1:0]  port7_i,
   output logic      [P7_W-1:0]  port7_o,
   output logic      [P7_W-1:0]  port7_oe,
   output logic      [P7_W-1:0]  port7_pu,
   input  wire logic [P8_W-1:0]  port8_i,
   output logic      [P8_W-1:0]  port8_o,
   output logic      [P8_W-1:0]  port8_oe,
   output logic      [P8_W-1:0]  port8_pu,
   input  wire logic [P9_W-1:0]  port9_i,
   output logic      [P9_W-1:0]  port9_o,
   output logic      [P9_W-1:0]  port9_oe,
   output logic      [P9_W-1:0]  port9_pu,
   input  wire logic [P10_W-1:0] port10_i,
   output logic      [P10_W-1:0] port10_o,
   output logic      [P10_W-1:0] port10_oe,
   output logic      [P10_W-1:0] port10_pu,
   input  wire logic [P12_W-1:0] port12_i,
   output logic      [P12_W-1:0] port12_o,
   output logic      [P12_W-1:0] port12_oe,
   output logic      [P12_W-1:0] port12_pu,
   input  wire logic [P13_W-1:0] port13_i,
   output logic      [P13_W-1:0] port13_o,
   output logic      [P13_W-1:0] port13_oe,
   output logic      [P13_W-1:0] port13_pu
);
   // Register state
   logic [P6_W-1:0]  p6_latch_r;
   logic [P7_W-1:0]  p7_latch_r;
   logic [P8_W-1:0]  p8_latch_r;
   logic [P9_W-1:0]  p9_latch_r;
   logic [P10_W-1:0] p10_latch_r;
   logic [P12_W-1:0] p12_latch_r;
   logic [P13_W-1:0] p13_latch_r;
   logic [P6_W-1:0]  port6_direction_reg;
   logic [P7_W-1:0]  port7_direction_reg;
   logic [P8_W-1:0]  port8_direction_reg;
   logic [P9_W-1:0]  port9_direction_reg;
   logic [P10_W-1:0] port10_direction_reg;
   logic [P12_W-1:0] port12_direction_reg;
   logic [P13_W-1:0] port13_direction_reg;
   logic [7:0]       pullup_option_low_group;
   logic [7:0]       pullup_option_high_group;
   logic [1:0]       mem_ctrl_r;
   logic             ser_async_r;
   logic [P7_W-1:0]  p7_ctl_r;
   logic [P10_W-1:0] p10_ctl_r;
   logic [P12_W-1:0] p12_ctl_r;
   logic [P13_W-1:0] p13_ctl_r;
   logic [DW-1:0]    prdata_r;
   logic             pslverr_r;

   logic             wr_en;
   logic             rd_setup;
   logic             exp_mode;
   logic             wait_used;
   logic             rt_we;
   logic [P12_W-1:0] rt_buf;
   logic [P12_W-1:0] rt_out;
   logic [DW-1:0]    rd_mux;
   logic             rd_hit;

   // Pin cell hookups
   logic [P6_W-1:0]  p6_ctl,  p6_alt_o,  p6_alt_oe,  p6_rd;
   logic [P7_W-1:0]  p7_ctl,  p7_alt_o,  p7_alt_oe,  p7_rd;
   logic [P8_W-1:0]  p8_ctl,  p8_rd;
   logic [P9_W-1:0]  p9_rd;
   logic [P10_W-1:0] p10_ctl, p10_alt_o, p10_alt_oe, p10_rd;
   logic [P12_W-1:0] p12_rd;
   logic [P13_W-1:0] p13_rd;

   // APB: zero-wait access, read data captured in the setup cycle
   assign wr_en    = psel & penable & pwrite;
   assign rd_setup = psel & ~penable;
   assign pready   = 1'b1;
   assign prdata   = prdata_r;
   assign pslverr  = pslverr_r;
   assign rt_we    = wr_en & (paddr == OFS_RT_BUF);

   assign exp_mode  = mem_ctrl_r[MEM_EXP_BIT];
   assign wait_used = mem_ctrl_r[MEM_EXP_BIT] & mem_ctrl_r[MEM_WAIT_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p6_latch_r  <= RST_LATCH;
         p7_latch_r  <= RST_LATCH[P7_W-1:0];
         p8_latch_r  <= RST_LATCH;
         p9_latch_r  <= RST_LATCH[P9_W-1:0];
         p10_latch_r <= RST_LATCH[P10_W-1:0];
         p12_latch_r <= RST_LATCH;
         p13_latch_r <= RST_LATCH[P13_W-1:0];
      end else if (wr_en) begin
         unique case (paddr)
            OFS_P6_LATCH:  p6_latch_r  <= pwdata[P6_W-1:0];
            OFS_P7_LATCH:  p7_latch_r  <= pwdata[P7_W-1:0];
            OFS_P8_LATCH:  p8_latch_r  <= pwdata[P8_W-1:0];
            OFS_P9_LATCH:  p9_latch_r  <= pwdata[P9_W-1:0];
            OFS_P10_LATCH: p10_latch_r <= pwdata[P10_W-1:0];
            OFS_P12_LATCH: p12_latch_r <= pwdata[P12_W-1:0];
            OFS_P13_LATCH: p13_latch_r <= pwdata[P13_W-1:0];
            default: ;
         endcase
      end
   end

   // Direction: 1 is input, 0 is output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port6_direction_reg  <= RST_DIR;
         port7_direction_reg  <= RST_DIR[P7_W-1:0];
         port8_direction_reg  <= RST_DIR;
         port9_direction_reg  <= RST_DIR[P9_W-1:0];
         port10_direction_reg <= RST_DIR[P10_W-1:0];
         port12_direction_reg <= RST_DIR;
         port13_direction_reg <= RST_DIR[P13_W-1:0];
      end else if (wr_en) begin
         unique case (paddr)
            OFS_P6_DIR:  port6_direction_reg  <= pwdata[P6_W-1:0];
            OFS_P7_DIR:  port7_direction_reg  <= pwdata[P7_W-1:0];
            OFS_P8_DIR:  port8_direction_reg  <= pwdata[P8_W-1:0];
            OFS_P9_DIR:  port9_direction_reg  <= pwdata[P9_W-1:0];
            OFS_P10_DIR: port10_direction_reg <= pwdata[P10_W-1:0];
            OFS_P12_DIR: port12_direction_reg <= pwdata[P12_W-1:0];
            OFS_P13_DIR: port13_direction_reg <= pwdata[P13_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pullup_option_low_group  <= RST_OPT;
         pullup_option_high_group <= RST_OPT;
         mem_ctrl_r               <= RST_OPT[1:0];
         ser_async_r              <= 1'b0;
         p7_ctl_r                 <= RST_OPT[P7_W-1:0];
         p10_ctl_r                <= RST_OPT[P10_W-1:0];
         p12_ctl_r                <= RST_OPT;
         p13_ctl_r                <= RST_OPT[P13_W-1:0];
      end else if (wr_en) begin
         unique case (paddr)
            OFS_PU_LOW:   pullup_option_low_group  <= pwdata[7:0];
            OFS_PU_HIGH:  pullup_option_high_group <= pwdata[7:0];
            OFS_MEM_CTRL: mem_ctrl_r  <= pwdata[1:0];
            OFS_SER_CTRL: ser_async_r <= pwdata[SER_ASYNC_BIT];
            OFS_P7_CTL:   p7_ctl_r    <= pwdata[P7_W-1:0];
            OFS_P10_CTL:  p10_ctl_r   <= pwdata[P10_W-1:0];
            OFS_P12_CTL:  p12_ctl_r   <= pwdata[P12_W-1:0];
            OFS_P13_CTL:  p13_ctl_r   <= pwdata[P13_W-1:0];
            default: ;
         endcase
      end
   end

   // Port 6: bus strobes on bits 4,5,7; wait on bit 6 only when used
   assign p6_ctl = {exp_mode, wait_used, exp_mode, exp_mode, 4'h0};
   assign p6_alt_o  = {address_latch_strobe, 1'b1, mem_wr_strobe_n,
                       mem_rd_strobe_n, 4'h0};
   assign p6_alt_oe = {1'b1, 1'b0, 1'b1, 1'b1, 4'h0};
   assign mem_wait_n = wait_used ? port6_i[6] : 1'b1;

   pfm_pin_cell #(
      .W       (P6_W),
      .OD_MASK (P6_OD_MASK),
      .PU_MASK (P6_PU_MASK)
   ) u_p6 (
      .latch   (p6_latch_r),
      .dir     (port6_direction_reg),
      .ctl     (p6_ctl),
      .alt_o   (p6_alt_o),
      .alt_oe  (p6_alt_oe),
      .pin_i   (port6_i),
      .pu_opt  (pullup_option_low_group[PUL_P6_BIT]),
      .pin_o   (port6_o),
      .pin_oe  (port6_oe),
      .pull_en (port6_pu),
      .rd_val  (p6_rd)
   );

   // Port 7: bit0 data in, bit1 data out, bit2 clock
   // In control mode the function sets value and enable; direction and latch drive the pin only in port mode but still select the readback
   assign p7_ctl    = p7_ctl_r;
   assign p7_alt_o  = {sync_serial_clock_ch2,
                       ser_async_r ? async_txd : sync_serial_out_ch2, 1'b0};
   assign p7_alt_oe = {~ser_async_r & sync_serial_clock_ch2_oe, 1'b1, 1'b0};
   // Idle high when the pin does not carry the function
   assign sync_serial_in_ch2   = (p7_ctl[0] & ~ser_async_r) ? port7_i[0] : 1'b1;
   assign async_rxd            = (p7_ctl[0] &  ser_async_r) ? port7_i[0] : 1'b1;
   assign sync_serial_clock_in = (p7_ctl[2] & ~ser_async_r) ? port7_i[2] : 1'b1;
   assign async_baud_clock_in  = (p7_ctl[2] &  ser_async_r) ? port7_i[2] : 1'b1;

   pfm_pin_cell #(
      .W       (P7_W),
      .OD_MASK ('0),
      .PU_MASK ('1)
   ) u_p7 (
      .latch   (p7_latch_r),
      .dir     (port7_direction_reg),
      .ctl     (p7_ctl),
      .alt_o   (p7_alt_o),
      .alt_oe  (p7_alt_oe),
      .pin_i   (port7_i),
      .pu_opt  (pullup_option_low_group[PUL_P7_BIT]),
      .pin_o   (port7_o),
      .pin_oe  (port7_oe),
      .pull_en (port7_pu),
      .rd_val  (p7_rd)
   );

   // Port 8: low address in expansion mode
   assign p8_ctl = {P8_W{exp_mode}};

   pfm_pin_cell #(
      .W       (P8_W),
      .OD_MASK ('0),
      .PU_MASK ('1)
   ) u_p8 (
      .latch   (p8_latch_r),
      .dir     (port8_direction_reg),
      .ctl     (p8_ctl),
      .alt_o   (mem_addr_lo),
      .alt_oe  ({P8_W{1'b1}}),
      .pin_i   (port8_i),
      .pu_opt  (pullup_option_high_group[PUH_P8_BIT]),
      .pin_o   (port8_o),
      .pin_oe  (port8_oe),
      .pull_en (port8_pu),
      .rd_val  (p8_rd)
   );

   // Port 9: low nibble pulls low only, no pull-up there
   pfm_pin_cell #(
      .W       (P9_W),
      .OD_MASK (P9_OD_MASK),
      .PU_MASK (P9_PU_MASK)
   ) u_p9 (
      .latch   (p9_latch_r),
      .dir     (port9_direction_reg),
      .ctl     ('0),
      .alt_o   ('0),
      .alt_oe  ('0),
      .pin_i   (port9_i),
      .pu_opt  (pullup_option_high_group[PUH_P9_BIT]),
      .pin_o   (port9_o),
      .pin_oe  (port9_oe),
      .pull_en (port9_pu),
      .rd_val  (p9_rd)
   );

   // Port 10: timer pins on bits 0 and 1; timer picks drive or sense
   assign p10_ctl    = p10_ctl_r & P10_ALT_MASK;
   assign p10_alt_o  = {2'b00, timer6_output, timer5_output};
   assign p10_alt_oe = {2'b00, timer6_out_en, timer5_out_en};
   assign timer5_ext_clock = p10_ctl[0] & port10_i[0];
   assign timer6_ext_clock = p10_ctl[1] & port10_i[1];

   pfm_pin_cell #(
      .W       (P10_W),
      .OD_MASK ('0),
      .PU_MASK ('1)
   ) u_p10 (
      .latch   (p10_latch_r),
      .dir     (port10_direction_reg),
      .ctl     (p10_ctl),
      .alt_o   (p10_alt_o),
      .alt_oe  (p10_alt_oe),
      .pin_i   (port10_i),
      .pu_opt  (pullup_option_high_group[PUH_P10_BIT]),
      .pin_o   (port10_o),
      .pin_oe  (port10_oe),
      .pull_en (port10_pu),
      .rd_val  (p10_rd)
   );

   // Port 12: real-time bits move only on the trigger
   pfm_rt_buffer u_rt (
      .pclk      (pclk),
      .presetn   (presetn),
      .buf_we    (rt_we),
      .buf_wdata (pwdata[P12_W-1:0]),
      .trigger   (realtime_trigger),
      .buf_q     (rt_buf),
      .out_q     (rt_out)
   );

   pfm_pin_cell #(
      .W       (P12_W),
      .OD_MASK ('0),
      .PU_MASK ('1)
   ) u_p12 (
      .latch   (p12_latch_r),
      .dir     (port12_direction_reg),
      .ctl     (p12_ctl_r),
      .alt_o   (rt_out),
      .alt_oe  ({P12_W{1'b1}}),
      .pin_i   (port12_i),
      .pu_opt  (pullup_option_high_group[PUH_P12_BIT]),
      .pin_o   (port12_o),
      .pin_oe  (port12_oe),
      .pull_en (port12_pu),
      .rd_val  (p12_rd)
   );

   // Port 13: digital driver off while the analog switch is closed
   assign dac_out_enable = p13_ctl_r;

   pfm_pin_cell #(
      .W       (P13_W),
      .OD_MASK ('0),
      .PU_MASK ('1)
   ) u_p13 (
      .latch   (p13_latch_r),
      .dir     (port13_direction_reg),
      .ctl     (p13_ctl_r),
      .alt_o   ('0),
      .alt_oe  ('0),
      .pin_i   (port13_i),
      .pu_opt  (pullup_option_high_group[PUH_P13_BIT]),
      .pin_o   (port13_o),
      .pin_oe  (port13_oe),
      .pull_en (port13_pu),
      .rd_val  (p13_rd)
   );

   // Read mux: port offsets return pin level on inputs, latch on outputs
   always_comb begin
      rd_mux = '0;
      rd_hit = 1'b1;
      unique case (paddr)
         OFS_P6_LATCH:  rd_mux[P6_W-1:0]  = p6_rd;
         OFS_P7_LATCH:  rd_mux[P7_W-1:0]  = p7_rd;
         OFS_P8_LATCH:  rd_mux[P8_W-1:0]  = p8_rd;
         OFS_P9_LATCH:  rd_mux[P9_W-1:0]  = p9_rd;
         OFS_P10_LATCH: rd_mux[P10_W-1:0] = p10_rd;
         OFS_P12_LATCH: rd_mux[P12_W-1:0] = p12_rd;
         OFS_P13_LATCH: rd_mux[P13_W-1:0] = p13_rd;
         OFS_P6_DIR:    rd_mux[P6_W-1:0]  = port6_direction_reg;
         OFS_P7_DIR:    rd_mux[P7_W-1:0]  = port7_direction_reg;
         OFS_P8_DIR:    rd_mux[P8_W-1:0]  = port8_direction_reg;
         OFS_P9_DIR:    rd_mux[P9_W-1:0]  = port9_direction_reg;
         OFS_P10_DIR:   rd_mux[P10_W-1:0] = port10_direction_reg;
         OFS_P12_DIR:   rd_mux[P12_W-1:0] = port12_direction_reg;
         OFS_P13_DIR:   rd_mux[P13_W-1:0] = port13_direction_reg;
         OFS_PU_LOW:    rd_mux[7:0]       = pullup_option_low_group;
         OFS_PU_HIGH:   rd_mux[7:0]       = pullup_option_high_group;
         OFS_MEM_CTRL:  rd_mux[1:0]       = mem_ctrl_r;
         OFS_SER_CTRL:  rd_mux[SER_ASYNC_BIT] = ser_async_r;
         OFS_P7_CTL:    rd_mux[P7_W-1:0]  = p7_ctl_r;
         OFS_P10_CTL:   rd_mux[P10_W-1:0] = p10_ctl_r;
         OFS_P12_CTL:   rd_mux[P12_W-1:0] = p12_ctl_r;
         OFS_P13_CTL:   rd_mux[P13_W-1:0] = p13_ctl_r;
         OFS_RT_BUF:    rd_mux[P12_W-1:0] = rt_buf;
         default:       rd_hit = 1'b0;
      endcase
   end

   // Captured in setup so the access phase sees stable flip-flop data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (rd_setup) begin
         prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
         pslverr_r <= ~rd_hit;
      end
   end
endmodule : pfm_port_mux

// file: sim/pfm_port_mux_asserts.sv
// Port-level checks for the upper-port pin function multiplexer
`timescale 1ns/10ps
module pfm_port_mux_asserts
   import pfm_pkg::*;
(
   input wire logic pclk, presetn, psel, penable, pwrite, timer5_ext_clock,
   input wire logic [P6_W-1:0]  port6_oe, port6_pu,
   input wire logic [P8_W-1:0]  port8_oe, port8_pu,
   input wire logic [P9_W-1:0]  port9_o, port9_pu,
   input wire logic [P10_W-1:0] port10_i,
   input wire logic [P12_W-1:0] port12_oe, port12_pu
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   rst_inputs_a: assert property ($rose(presetn) |-> (port8_oe | port6_oe) == 0)
      else $error("pin driven after reset");
   p8_pull_a: assert property ((port8_pu & port8_oe) == 0)
      else $error("port8 pull-up on driven pin");
   p6_pull_a: assert property (port6_pu[3:0] == 0 && (port6_pu & port6_oe) == 0)
      else $error("port6 pull-up misplaced");
   p9_drain_a: assert property (port9_o[3:0] == 0)
      else $error("port9 open drain drives high");
   p9_pull_a: assert property (port9_pu[3:0] == 0)
      else $error("port9 low pull-up on");
   p12_pull_a: assert property ((port12_pu & port12_oe) == 0)
      else $error("port12 pull-up on driven pin");
   t5_clock_a: assert property (timer5_ext_clock |-> port10_i[0])
      else $error("timer5 clock without pin");
   p12_dir_a: assert property ($changed(port12_oe) |-> $past(psel && penable && pwrite))
      else $error("port12 enable moved without write");
endmodule : pfm_port_mux_asserts

// file: sim/pfm_pin_partner.sv
// Pin environment: peer drivers, pull-ups and floating pins
`timescale 1ns/10ps
module pfm_pin_partner (
   input  wire logic        pclk,
   input  wire logic [39:0] o, oe, pu, ext, ext_en,
   output logic      [39:0] pin_i
);
   logic flt_r = 1'b0;
   // A floating pin toggles so a stale level never passes for a driven one
   always @(posedge pclk) flt_r <= ~flt_r;
   always_comb for (int k = 0; k < 40; k++)
      pin_i[k] = oe[k] ? o[k] : ext_en[k] ? ext[k] : pu[k] ? 1'b1 : flt_r;
endmodule : pfm_pin_partner

// file: sim/test_pfm_port_mux.sv
// Self-checking bench for the upper-port pin function multiplexer
`timescale 1ns/10ps
module test_pfm_port_mux;
   import pfm_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, realtime_trigger = 0;
   logic mem_rd_strobe_n = 0, mem_wr_strobe_n = 1, address_latch_strobe = 1, async_txd = 0;
   logic sync_serial_out_ch2 = 1, sync_serial_clock_ch2 = 0, sync_serial_clock_ch2_oe = 1;
   logic timer5_output = 1, timer6_output = 0, timer5_out_en = 1, timer6_out_en = 1;
   logic [7:0] paddr = 0, mem_addr_lo = 8'h5A;
   logic [31:0] pwdata = 0, prdata, rd_q;
   logic [39:0] ext = '1, ext_en = '1;
   logic pready, pslverr, mem_wait_n, sync_serial_in_ch2, sync_serial_clock_in, async_rxd;
   logic async_baud_clock_in, timer5_ext_clock, timer6_ext_clock;
   logic [1:0] dac_out_enable, port13_i, port13_o, port13_oe, port13_pu;
   logic [2:0] port7_i, port7_o, port7_oe, port7_pu;
   logic [3:0] port10_i, port10_o, port10_oe, port10_pu;
   logic [6:0] port9_i, port9_o, port9_oe, port9_pu;
   logic [7:0] port6_i, port6_o, port6_oe, port6_pu, port8_i, port8_o, port8_oe, port8_pu;
   logic [7:0] port12_i, port12_o, port12_oe, port12_pu;
   int error_cnt = 0, num_checks = 0;
   pfm_port_mux dut_u (.*);
   pfm_pin_partner env_u (.pclk(pclk), .ext(ext), .ext_en(ext_en),
      .o({port13_o, port12_o, port10_o, port9_o, port8_o, port7_o, port6_o}),
      .oe({port13_oe, port12_oe, port10_oe, port9_oe, port8_oe, port7_oe, port6_oe}),
      .pu({port13_pu, port12_pu, port10_pu, port9_pu, port8_pu, port7_pu, port6_pu}),
      .pin_i({port13_i, port12_i, port10_i, port9_i, port8_i, port7_i, port6_i}));
   initial forever #2.5 pclk = ~pclk;
   task automatic chk(input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Ends off the edge so pins can be checked straight after a write
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd_q = prdata;
      {psel, penable} <= 2'b00;
      @(negedge pclk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(0, a, 0);
      chk(rd_q, e);
   endtask : rd
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      #20000;
      error_cnt++;
      $display("Error at %0t: timeout", $time);
      tally_and_finish();
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      @(negedge pclk);
      chk({port8_oe, port6_oe, port8_pu}, 0);
      rd(OFS_P8_DIR, 8'hFF);
      rd(OFS_P7_DIR, 3'h7);
      rd(OFS_P9_DIR, 7'h7F);
      rd(OFS_P10_DIR, 4'hF);
      rd(8'h7C, 0);
      chk(pslverr, 1);
      $display("reset test done");
      wr(OFS_P8_DIR, 8'h0F);
      wr(OFS_P8_LATCH, 8'hA5);
      wr(OFS_PU_HIGH, 8'h11);
      @(posedge pclk) ext_en[18:11] <= 0;
      rd(OFS_P8_LATCH, 8'hAF);
      chk({port8_oe, port8_pu, port8_o[3:0]}, 20'hF_00F5);
      wr(OFS_PU_LOW, 8'h40);
      wr(OFS_MEM_CTRL, 1);
      chk({port8_o, port8_pu}, 16'h5A00);
      chk({port6_oe[7:4], port6_pu[7:4], port6_o[7:4]}, 12'hB4A);
      wr(OFS_P6_LATCH, 8'h40);
      wr(OFS_P6_DIR, 8'hBF);
      chk({port6_oe[6], port6_o[6]}, 2'b11);
      @(posedge pclk) ext[6] <= 0;
      wr(OFS_MEM_CTRL, 3);
      chk({port6_oe[6], port6_pu[6], mem_wait_n}, 3'b000);
      $display("bus test done");
      wr(OFS_P7_DIR, 3'h5);
      wr(OFS_SER_CTRL, 1);
      wr(OFS_P7_CTL, 3'h7);
      @(posedge pclk) {ext[10], ext[8]} <= 2'b00;
      @(negedge pclk);
      chk({async_rxd, sync_serial_in_ch2, async_baud_clock_in, sync_serial_clock_in,
         port7_oe[1], port7_o[1]}, 6'h16);
      wr(OFS_SER_CTRL, 0);
      chk({sync_serial_in_ch2, async_rxd, sync_serial_clock_in, port7_oe[2],
         port7_o[2:1]}, 6'h15);
      wr(OFS_P10_CTL, 4'hF);
      chk({port10_oe[1:0], port10_o[1:0], timer6_ext_clock, timer5_ext_clock}, 6'h35);
      wr(OFS_RT_BUF, 8'h3C);
      wr(OFS_P12_CTL, 8'hFF);
      chk({port12_o, port12_pu}, 0);
      @(posedge pclk) realtime_trigger <= 1;
      @(posedge pclk) realtime_trigger <= 0;
      @(negedge pclk);
      chk({port12_oe, port12_o}, 16'hFF3C);
      wr(OFS_P13_CTL, 2'h2);
      chk({dac_out_enable, port13_oe}, 4'h8);
      wr(OFS_P13_DIR, 2'h2);
      chk({port13_oe, port13_o}, 4'h4);
      wr(OFS_P9_DIR, 0);
      wr(OFS_P9_LATCH, 7'h0A);
      chk({port9_oe, port9_o[3:0]}, 11'h750);
      $display("function test done");
      @(posedge pclk) presetn <= 0;
      @(negedge pclk);
      chk({port12_oe, port8_oe, port6_oe, port10_oe, port9_oe}, 0);
      @(posedge pclk) presetn <= 1;
      @(negedge pclk);
      chk({mem_wait_n, sync_serial_in_ch2, sync_serial_clock_in, async_rxd, async_baud_clock_in,
         timer5_ext_clock, timer6_ext_clock, dac_out_enable, port12_o}, 17'h1_F000);
      rd(OFS_MEM_CTRL, 0);
      $display("mid-run reset test done");
      tally_and_finish();
   end
endmodule : test_pfm_port_mux
bind pfm_port_mux pfm_port_mux_asserts chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .timer5_ext_clock(timer5_ext_clock), .port6_oe(port6_oe), .port6_pu(port6_pu),
   .port8_oe(port8_oe), .port8_pu(port8_pu), .port9_o(port9_o), .port9_pu(port9_pu),
   .port10_i(port10_i), .port12_oe(port12_oe), .port12_pu(port12_pu));
